/* File: inc/fps_map.svh */
// Function
// R01 - Drive a 12-bit active-high VF status bus, two bits per VF, VF0 lowest.
// R02 - Even bit of each pair is set while that VF is enabled by software.
// R03 - Odd bit of each pair mirrors that VF's bus master enable.
// R04 - The pair pattern repeats for VF0 through VF5.
// R05 - 6-bit PF power output: PF0 in bits 2:0, PF1 in bits 5:3.
// R06 - Power codes: 000 D0_uninit, 001 D0_active, 010 D1, 100 D3_hot.
// R07 - In Root Port mode every PF and VF power field reads 000.
// R08 - 18-bit VF power output, one 3-bit field per VF, VF0 lowest.
// R09 - Link power output: 00 L0, 01 L0s, 10 L1, 11 L2 or reserved.
// R10 - Outputs follow state changes on the user clock and hold in between.
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------
`define FPS_ADDR_CTRL 6'h00
`define FPS_ADDR_VF_CFG 6'h04
`define FPS_ADDR_PF_PWR 6'h08
`define FPS_ADDR_VF_PWR 6'h0C
`define FPS_ADDR_LINK 6'h10
`define FPS_ADDR_STAT_VF 6'h14
`define FPS_ADDR_STAT_PWR 6'h18

// ----------------------------------------------------------------
// Field positions and widths.
// ----------------------------------------------------------------
`define FPS_CTRL_ROOT_BIT 0
`define FPS_VF_BME_LSB 8
`define FPS_STAT_VFPWR_LSB 8
`define FPS_CODE_W 3
`define FPS_IDX_W 2

// ----------------------------------------------------------------
// Power state codes.
// ----------------------------------------------------------------
`define FPS_CODE_D0_UNINIT 3'h0
`define FPS_CODE_D0_ACTIVE 3'h1
`define FPS_CODE_D1 3'h2
`define FPS_CODE_D3_HOT 3'h4

// ----------------------------------------------------------------
// Bus answers and reset values.
// ----------------------------------------------------------------
`define FPS_RESP_OKAY 2'h0
`define FPS_RESP_DECERR 2'h3
`define FPS_RST_WORD 32'h0000_0000

`endif

/* File: inc/fps_pkg.sv */
`default_nettype none
package fps_pkg;

	// Power state index as software writes it.
	typedef enum logic [1:0] {
		FPS_D0_UNINIT = 2'h0,
		FPS_D0_ACTIVE = 2'h1,
		FPS_D1 = 2'h2,
		FPS_D3_HOT = 2'h3
	} fps_dstate_t;

endpackage
`default_nettype wire

/* File: src/fps_status_out.sv */
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fps_map.svh"

module fps_status_out #(
	parameter int NUM_VF = 6,
	parameter int NUM_PF = 2
) (
	input wire logic aclk, // User clock, 250 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [5:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address taken.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte enables.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data taken.
	output logic [1:0] s_axi_bresp, // Write response code.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response accepted.
	input wire logic [5:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address taken.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response code.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data accepted.
	output logic [2*NUM_VF-1:0] virtual_fn_enable_status, // VF enable and bus master.
	output logic [3*NUM_PF-1:0] pf_dstate, // Physical function power states.
	output logic [3*NUM_VF-1:0] virtual_fn_dstate, // Virtual function power states.
	output logic [1:0] link_power_state // Link power state.
);
	import fps_pkg::*;

	// ----------------------------------------------------------------
	// Configuration state written by software.
	// ----------------------------------------------------------------
	logic root_port_q;
	logic [NUM_VF-1:0] vf_en_q;
	logic [NUM_VF-1:0] vf_bme_q;
	logic [`FPS_IDX_W*NUM_PF-1:0] pf_idx_q;
	logic [`FPS_IDX_W*NUM_VF-1:0] vf_idx_q;
	logic [1:0] link_q;

	// Output flops and their next values.
	logic [2*NUM_VF-1:0] vf_stat_q;
	logic [2*NUM_VF-1:0] vf_stat_d;
	logic [3*NUM_PF-1:0] pf_pwr_q;
	logic [3*NUM_PF-1:0] pf_pwr_d;
	logic [3*NUM_VF-1:0] vf_pwr_q;
	logic [3*NUM_VF-1:0] vf_pwr_d;
	logic [1:0] link_pwr_q;

	// Bus handshake state.
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [5:0] waddr_q;
	logic [5:0] raddr_q;
	logic wr_go;
	logic rd_go;

	// ----------------------------------------------------------------
	// Power state encoding.
	// ----------------------------------------------------------------

	// Maps a software state index to the documented three-bit code.
	function automatic logic [2:0] fps_encode(input logic [1:0] idx, input logic root);
		logic [2:0] code;
		code = `FPS_CODE_D0_UNINIT;
		unique case (fps_dstate_t'(idx))
			FPS_D0_UNINIT: code = `FPS_CODE_D0_UNINIT;
			FPS_D0_ACTIVE: code = `FPS_CODE_D0_ACTIVE;
			FPS_D1: code = `FPS_CODE_D1;
			FPS_D3_HOT: code = `FPS_CODE_D3_HOT;
		endcase
		if (root) begin
			code = `FPS_CODE_D0_UNINIT; // [R07]
		end
		return code; // [R06]
	endfunction

	// Per-VF status pair and power field, VF0 in the lowest slot.
	genvar gv;
	generate
		for (gv = 0; gv < NUM_VF; gv++) begin : g_vf
			assign vf_stat_d[2*gv] = vf_en_q[gv]; // [R01] [R02] [R04]
			assign vf_stat_d[2*gv+1] = vf_bme_q[gv]; // [R03] [R04]
			assign vf_pwr_d[3*gv +: 3] = fps_encode(
				vf_idx_q[`FPS_IDX_W*gv +: `FPS_IDX_W], root_port_q); // [R08]
		end
	endgenerate

	// Per-PF power field, PF0 in the low bits.
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PF; gp++) begin : g_pf
			assign pf_pwr_d[3*gp +: 3] = fps_encode(
				pf_idx_q[`FPS_IDX_W*gp +: `FPS_IDX_W], root_port_q); // [R05]
		end
	endgenerate

	// ----------------------------------------------------------------
	// Status outputs.
	// ----------------------------------------------------------------

	// Outputs are registered once per clock so they only move on aclk.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vf_stat_q <= '0;
			pf_pwr_q <= '0;
			vf_pwr_q <= '0;
			link_pwr_q <= 2'h0;
		end else begin
			vf_stat_q <= vf_stat_d; // [R10]
			pf_pwr_q <= pf_pwr_d; // [R10]
			vf_pwr_q <= vf_pwr_d; // [R10]
			link_pwr_q <= link_q; // [R09] [R10]
		end
	end

	assign virtual_fn_enable_status = vf_stat_q;
	assign pf_dstate = pf_pwr_q;
	assign virtual_fn_dstate = vf_pwr_q;
	assign link_power_state = link_pwr_q;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel.
	// ----------------------------------------------------------------

	// Address and data are taken together in one cycle once both wait.
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;

	// Ready pulses for one cycle; the response follows on the next edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'h0;
			wready_q <= 1'h0;
			bvalid_q <= 1'h0;
			bresp_q <= `FPS_RESP_OKAY;
			waddr_q <= 6'h00;
		end else begin
			awready_q <= wr_go;
			wready_q <= wr_go;
			if (wr_go) begin
				waddr_q <= s_axi_awaddr;
			end
			if (awready_q) begin
				bvalid_q <= 1'h1;
				unique case (waddr_q)
					`FPS_ADDR_CTRL, `FPS_ADDR_VF_CFG, `FPS_ADDR_PF_PWR,
					`FPS_ADDR_VF_PWR, `FPS_ADDR_LINK: bresp_q <= `FPS_RESP_OKAY;
					default: bresp_q <= `FPS_RESP_DECERR;
				endcase
			end else if (s_axi_bready) begin
				bvalid_q <= 1'h0;
			end
		end
	end

	// Writable configuration, updated on the cycle the write is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			root_port_q <= 1'h0;
			vf_en_q <= '0;
			vf_bme_q <= '0;
			pf_idx_q <= '0;
			vf_idx_q <= '0;
			link_q <= 2'h0;
		end else if (wr_go) begin
			unique case (s_axi_awaddr)
				`FPS_ADDR_CTRL: begin
					if (s_axi_wstrb[0]) begin
						root_port_q <= s_axi_wdata[`FPS_CTRL_ROOT_BIT];
					end
				end
				`FPS_ADDR_VF_CFG: begin
					if (s_axi_wstrb[0]) begin
						vf_en_q <= s_axi_wdata[NUM_VF-1:0];
					end
					if (s_axi_wstrb[1]) begin
						vf_bme_q <= s_axi_wdata[`FPS_VF_BME_LSB +: NUM_VF];
					end
				end
				`FPS_ADDR_PF_PWR: begin
					if (s_axi_wstrb[0]) begin
						pf_idx_q <= s_axi_wdata[`FPS_IDX_W*NUM_PF-1:0];
					end
				end
				`FPS_ADDR_VF_PWR: begin
					if (s_axi_wstrb[0] && s_axi_wstrb[1]) begin
						vf_idx_q <= s_axi_wdata[`FPS_IDX_W*NUM_VF-1:0];
					end
				end
				`FPS_ADDR_LINK: begin
					if (s_axi_wstrb[0]) begin
						link_q <= s_axi_wdata[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel.
	// ----------------------------------------------------------------

	// A read is taken only when no earlier answer is still pending.
	assign rd_go = s_axi_arvalid && !arready_q && !rvalid_q;

	// Read data is captured one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'h0;
			rvalid_q <= 1'h0;
			rdata_q <= `FPS_RST_WORD;
			rresp_q <= `FPS_RESP_OKAY;
			raddr_q <= 6'h00;
		end else begin
			arready_q <= rd_go;
			if (rd_go) begin
				raddr_q <= s_axi_araddr;
			end
			if (arready_q) begin
				rvalid_q <= 1'h1;
				rresp_q <= `FPS_RESP_OKAY;
				rdata_q <= `FPS_RST_WORD;
				unique case (raddr_q)
					`FPS_ADDR_CTRL: rdata_q[`FPS_CTRL_ROOT_BIT] <= root_port_q;
					`FPS_ADDR_VF_CFG: begin
						rdata_q[NUM_VF-1:0] <= vf_en_q;
						rdata_q[`FPS_VF_BME_LSB +: NUM_VF] <= vf_bme_q;
					end
					`FPS_ADDR_PF_PWR: rdata_q[`FPS_IDX_W*NUM_PF-1:0] <= pf_idx_q;
					`FPS_ADDR_VF_PWR: rdata_q[`FPS_IDX_W*NUM_VF-1:0] <= vf_idx_q;
					`FPS_ADDR_LINK: rdata_q[1:0] <= link_q;
					`FPS_ADDR_STAT_VF: rdata_q[2*NUM_VF-1:0] <= vf_stat_q;
					`FPS_ADDR_STAT_PWR: begin
						rdata_q[3*NUM_PF-1:0] <= pf_pwr_q;
						rdata_q[`FPS_STAT_VFPWR_LSB +: 3*NUM_VF] <= vf_pwr_q;
					end
					default: rresp_q <= `FPS_RESP_DECERR;
				endcase
			end else if (s_axi_rready) begin
				rvalid_q <= 1'h0;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

/* File: dv/fps_status_out_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module fps_status_out_checker #(
	parameter int NUM_VF = 6,
	parameter int NUM_PF = 2
) (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Reset.
	input wire logic [5:0] s_axi_awaddr, // Address.
	input wire logic s_axi_awvalid, // Valid.
	input wire logic s_axi_awready, // Taken.
	input wire logic [31:0] s_axi_wdata, // Data.
	input wire logic [3:0] s_axi_wstrb, // Strobes.
	input wire logic s_axi_wvalid, // Valid.
	input wire logic s_axi_wready, // Taken.
	input wire logic [1:0] s_axi_bresp, // Code.
	input wire logic s_axi_bvalid, // Valid.
	input wire logic s_axi_bready, // Ready.
	input wire logic [5:0] s_axi_araddr, // Address.
	input wire logic s_axi_arvalid, // Valid.
	input wire logic s_axi_arready, // Taken.
	input wire logic [31:0] s_axi_rdata, // Data.
	input wire logic [1:0] s_axi_rresp, // Code.
	input wire logic s_axi_rvalid, // Valid.
	input wire logic s_axi_rready, // Ready.
	input wire logic [2*NUM_VF-1:0] virtual_fn_enable_status, // Enables.
	input wire logic [3*NUM_PF-1:0] pf_dstate, // PF states.
	input wire logic [3*NUM_VF-1:0] virtual_fn_dstate, // VF states.
	input wire logic [1:0] link_power_state // Link state.
);
	// ------
	// Requests accepted by the slave.
	// ------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic wr_go, rd_go;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	a_write_timing: assert property (
		wr_go |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
		else $error("write answer late");
	a_read_timing: assert property (rd_go |=> s_axi_arready ##1 s_axi_rvalid)
		else $error("read answer late");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_unmapped_read: assert property (
		rd_go && s_axi_araddr > 6'h18 |=> ##1 s_axi_rresp == 2'h3)
		else $error("unmapped read not refused");
	a_root_zero: assert property (
		wr_go && s_axi_awaddr == 6'h00 && s_axi_wstrb[0] && s_axi_wdata[0]
		|=> ##1 pf_dstate == '0 && virtual_fn_dstate == '0)
		else $error("root mode power not zero");
	a_outs_stable: assert property (
		!$stable({virtual_fn_enable_status, pf_dstate, virtual_fn_dstate, link_power_state})
		|-> s_axi_awready || $past(s_axi_awready) || $past(!aresetn))
		else $error("status moved without a write");
	for (genvar i = 0; i < NUM_VF; i++) begin : g_vf
		a_vf_code: assert property ($onehot0(virtual_fn_dstate[3*i+:3]))
			else $error("bad vf power code");
	end
	for (genvar j = 0; j < NUM_PF; j++) begin : g_pf
		a_pf_code: assert property ($onehot0(pf_dstate[3*j+:3]))
			else $error("bad pf power code");
	end
	c_write: cover property (wr_go);
	c_read: cover property (rd_go);
	c_refuse: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule
bind fps_status_out fps_status_out_checker #(.NUM_VF(NUM_VF), .NUM_PF(NUM_PF))
	fps_status_out_checker_inst (.*);
`default_nettype wire

/* File: dv/fps_user_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fps_user_model (
	input wire logic aclk, // User clock.
	input wire logic [11:0] en_status, // VF enables.
	input wire logic [5:0] pf_state, // PF states.
	input wire logic [17:0] vf_state, // VF states.
	input wire logic [1:0] link_state, // Link state.
	output logic [37:0] seen_q // Sampled status.
);
	// Samples the status levels once a clock, as user logic does.
	always_ff @(posedge aclk) begin
		seen_q <= {en_status, pf_state, vf_state, link_state};
	end
endmodule
`default_nettype wire

/* File: dv/fps_status_out_test.sv */
`timescale 1ns/1ns
`default_nettype none
module fps_status_out_test;
	logic aclk, aresetn, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv;
	logic [5:0] awa, ara;
	logic [31:0] wd, rdd, seed, d, vw;
	logic [1:0] bres, rres, lps;
	logic [3:0] ws;
	logic [11:0] ens, ev;
	logic [5:0] pfs;
	logic [17:0] vfs, evd;
	logic [37:0] seen;
	int n_mismatch, n_checks;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	fps_status_out fps_status_out_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bres), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdd), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.virtual_fn_enable_status(ens), .pf_dstate(pfs), .virtual_fn_dstate(vfs),
		.link_power_state(lps));
	fps_user_model fps_user_model_inst (.aclk(aclk), .en_status(ens), .pf_state(pfs),
		.vf_state(vfs), .link_state(lps), .seen_q(seen));
	// Free-running 4 ns clock.
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [2:0] enc(input logic [1:0] i);
		return (i == 2'h3) ? 3'h4 : {1'h0, i};
	endfunction
	task automatic cmp(input logic [37:0] g, input logic [37:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] r);
		bq.push_back(r);
		awa <= a;
		wd <= v;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do @(posedge aclk); while (!awr);
		awv <= 1'h0;
		wv <= 1'h0;
		do @(posedge aclk); while (!bv);
		br <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [33:0] e);
		rq.push_back(e);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do @(posedge aclk); while (!arr);
		arv <= 1'h0;
		do @(posedge aclk); while (!rv);
		rr <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Bus answers are matched against the oldest expected note.
	always @(posedge aclk) begin
		if (bv && br) cmp({36'h0, bres}, {36'h0, bq.pop_front()});
		if (rv && rr) cmp({4'h0, rres, rdd}, {4'h0, rq.pop_front()});
	end
	// Cuts a hang short.
	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		results();
	end
	// Main sequence.
	initial begin
		{aresetn, awv, wv, br, arv, rr, awa, ara, wd, vw} = '0;
		seed = 32'h8CFE6B9F;
		ws = 4'hF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		cmp(seen, 38'h0);
		rd(6'h14, 34'h0);
		$display("reset test done");
		repeat (4) begin
			d = xs();
			for (int n = 0; n < 6; n++) {ev[2*n+1], ev[2*n]} = {d[8+n], d[n]};
			wr(6'h04, d, 2'h0);
			repeat (3) @(posedge aclk);
			cmp({26'h0, seen[37:26]}, {26'h0, ev});
			rd(6'h14, {22'h0, ev});
		end
		// Low byte only: enables move, bus master bits keep their last value.
		ws <= 4'h1;
		d = xs();
		for (int n = 0; n < 6; n++) ev[2*n] = d[n];
		wr(6'h04, d, 2'h0);
		ws <= 4'hF;
		repeat (3) @(posedge aclk);
		cmp({26'h0, seen[37:26]}, {26'h0, ev});
		$display("vf status test done");
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 6; i++) {vw[2*i+:2], evd[3*i+:3]} = {2'(k+i), enc(2'(k+i))};
			wr(6'h08, {28'h0, vw[3:0]}, 2'h0);
			wr(6'h0C, vw, 2'h0);
			wr(6'h10, {30'h0, 2'(k)}, 2'h0);
			repeat (3) @(posedge aclk);
			cmp({12'h0, seen[25:0]}, {12'h0, evd[5:0], evd, 2'(k)});
			rd(6'h18, {8'h0, evd, 2'h0, evd[5:0]});
		end
		$display("power test done");
		wr(6'h00, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		cmp({12'h0, seen[25:0]}, 38'h3);
		rd(6'h18, 34'h0);
		wr(6'h00, 32'h0, 2'h0);
		$display("root test done");
		// A reset in mid-run must clear status that is now non-zero.
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		cmp(seen, 38'h0);
		$display("second reset test done");
		rd(6'h1C, {2'h3, 32'h0});
		wr(6'h14, xs(), 2'h3);
		wr(6'h3C, 32'h0, 2'h3);
		$display("refusal test done");
		results();
	end
endmodule
`default_nettype wire
